// *** src/keypad_level_interrupt.sv ***
// Keypad level interrupt top with register port
`timescale 1ns/100ps
module keypad_level_interrupt
  import keypad_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_CE,
  input wire logic [7:0] I_FIRST_IO_PORT,
  input wire logic I_KEYPAD_GLOBAL_IRQ_ENABLE,
  input wire logic I_RD,
  input wire logic I_WR,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_RDATA,
  output logic O_KEYPAD_IRQ_REQUEST,
  output logic O_WAKE
);
  typedef struct packed {
    line_cfg_type cfg;
    logic [7:0] rdata;
    logic irq;
    logic wake;
  } state_type;
  state_type st_r;
  state_type st_nxt;
  reg_req_type req;
  logic [7:0] hit;
  logic [7:0] flags;
  logic flag_read;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Register select: a strobe aimed at one fixed register address
  function automatic logic reg_sel(input logic strobe,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
    reg_sel = strobe && (addr == target);
  endfunction

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign req = '{rd: I_RD, wr: I_WR, addr: I_ADDR, wdata: I_WDATA};
  assign flag_read = reg_sel(req.rd, req.addr, LINE_FLAGS_ADDR);

  keypad_detect #(.WIDTH(LINES)) u_detect (
    .i_lines(I_FIRST_IO_PORT),
    .i_level_select(st_r.cfg.level_select),
    .o_hit(hit)
  );

  keypad_regs #(.WIDTH(LINES)) u_regs (
    .clk(I_SYS_CLK),
    .rst_n(I_RSTN),
    .ce(I_CE),
    .i_hit(hit),
    .i_clear(flag_read),
    .o_flags(flags)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (reg_sel(req.wr, req.addr, LEVEL_SELECT_ADDR)) begin
      st_nxt.cfg.level_select = req.wdata;
    end
    if (reg_sel(req.wr, req.addr, LINE_ENABLE_ADDR)) begin
      st_nxt.cfg.line_enables = req.wdata;
    end
    st_nxt.rdata = st_r.rdata;
    if (req.rd) begin
      case (req.addr)
        LEVEL_SELECT_ADDR: st_nxt.rdata = st_r.cfg.level_select;
        LINE_ENABLE_ADDR: st_nxt.rdata = st_r.cfg.line_enables;
        LINE_FLAGS_ADDR: st_nxt.rdata = flags;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // Masked flags merged onto one request
    st_nxt.irq = I_KEYPAD_GLOBAL_IRQ_ENABLE &&
                 |(flags & st_r.cfg.line_enables);
    // Wake on any enabled line showing its level
    st_nxt.wake = |(hit & st_r.cfg.line_enables);
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      st_r <= '{cfg: '{level_select: LINE_RESET, line_enables: LINE_RESET},
                rdata: 8'h00, irq: 1'b0, wake: 1'b0};
    end else if (I_CE) begin
      st_r <= st_nxt;
    end
  end

  assign O_RDATA = st_r.rdata;
  assign O_KEYPAD_IRQ_REQUEST = st_r.irq;
  assign O_WAKE = st_r.wake;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  AST_GLOBAL_GATE: assert property (
    I_CE && !I_KEYPAD_GLOBAL_IRQ_ENABLE |=> !O_KEYPAD_IRQ_REQUEST)
    else $error("request without global enable");
  AST_MASKED: assert property (
    I_CE && (flags & st_r.cfg.line_enables) == 8'h00 |=>
      !O_KEYPAD_IRQ_REQUEST)
    else $error("masked flag raised request");
  AST_SET: assert property (
    I_CE && hit[0] |=> flags[0])
    else $error("flag not set by level");
  AST_CLEAR: assert property (
    I_CE && flag_read && hit == 8'h00 |=> flags == 8'h00)
    else $error("read did not clear flags");
  AST_SET_WINS: assert property (
    I_CE && flag_read && hit[7] |=> flags[7])
    else $error("set lost to clear");
  AST_LOW_LEVEL: assert property (
    !st_r.cfg.level_select[1] && !I_FIRST_IO_PORT[1] |-> hit[1])
    else $error("low level missed");
  AST_REQ: assert property (
    I_CE && I_KEYPAD_GLOBAL_IRQ_ENABLE && |(flags & st_r.cfg.line_enables)
      |=> O_KEYPAD_IRQ_REQUEST)
    else $error("request missing");
  AST_WAKE: assert property (
    I_CE && |(hit & st_r.cfg.line_enables) |=> O_WAKE)
    else $error("wake missing");
  AST_CFG: assert property (
    I_CE && req.wr && req.addr == LINE_ENABLE_ADDR |=>
      st_r.cfg.line_enables == $past(I_WDATA))
    else $error("enable write lost");

  AST_FREEZE: assert property (
    !I_CE |=> $stable(st_r))
    else $error("state moved with clock enable low");
  AST_HIGH_LEVEL: assert property (
    st_r.cfg.level_select[4] && I_FIRST_IO_PORT[4] |-> hit[4])
    else $error("high level missed");
  AST_RDATA: assert property (
    I_CE && flag_read |=> O_RDATA == $past(flags))
    else $error("flag read data wrong");
  AST_NO_WAKE: assert property (
    I_CE && (hit & st_r.cfg.line_enables) == 8'h00 |=> !O_WAKE)
    else $error("wake from a disabled line");

  COV_IRQ: cover property (O_KEYPAD_IRQ_REQUEST);
  COV_HIGH: cover property (|(hit & st_r.cfg.level_select));
  COV_CLR: cover property (flag_read && flags != 8'h00);
  COV_WAKE: cover property (O_WAKE);
endmodule

// *** inc/keypad_pkg.sv ***
// Keypad interrupt constants, types and operation summary
// Operation
// - Eight keypad inputs on port one, each interrupting on a chosen level.
// - A qualifying level on any enabled keypad input wakes core from idle and power-down.
// - Eight lines are separate sources merged into one request, one vector.
// - Global enable bit gates the merged request; cleared means no interrupt.
// - Each line follows its level-select bit; detection sets its own flag.
// - A flag feeds the merged request only when its mask bit allows it.
// - Hardware sets a flag while its line shows the programmed level.
// - Software read of flag register at 9Eh clears the flags whose lines no longer show their level.
// - Flag register reads zero after reset.
// - Masking allows one to eight row matrices; other lines stay quiet.
// - Level select at 9Ch resets zero; zero means low, one means high.
// - Line enable at 9Dh resets zero; set bit lets flag raise request.
package keypad_pkg;
  localparam int LINES = 8;
  localparam logic [7:0] LEVEL_SELECT_ADDR = 8'h9c;
  localparam logic [7:0] LINE_ENABLE_ADDR = 8'h9d;
  localparam logic [7:0] LINE_FLAGS_ADDR = 8'h9e;
  localparam logic [7:0] LINE_RESET = 8'h00;

  // Register access strobe bundle from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Per-line configuration
  typedef struct packed {
    logic [7:0] level_select;
    logic [7:0] line_enables;
  } line_cfg_type;
endpackage

// *** src/keypad_detect.sv ***
// Per-line level detection for keypad inputs
`timescale 1ns/100ps
module keypad_detect
  import keypad_pkg::*;
#(
  parameter int WIDTH = LINES
) (
  input wire logic [WIDTH-1:0] i_lines,
  input wire logic [WIDTH-1:0] i_level_select,
  output logic [WIDTH-1:0] o_hit
);
  // Match each line against its selected level
  always_comb begin
    o_hit = ~(i_lines ^ i_level_select);
  end
endmodule

// *** src/keypad_regs.sv ***
// Flag register with read-to-clear and set priority
`timescale 1ns/100ps
module keypad_regs
  import keypad_pkg::*;
#(
  parameter int WIDTH = LINES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] i_hit,
  input wire logic i_clear,
  output logic [WIDTH-1:0] o_flags
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } state_type;
  state_type st_r;
  state_type st_nxt;

  // Set wins over read clear
  always_comb begin
    st_nxt = st_r;
    if (i_clear) begin
      st_nxt.flags = '0;
    end
    st_nxt.flags = st_nxt.flags | i_hit;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
  assign o_flags = st_r.flags;
endmodule

// *** tb/keypad_matrix_model.sv ***
// Matrix keypad rows seen on the port-one lines
`timescale 1ns/100ps
module keypad_matrix_model (
  input wire logic [7:0] i_press,
  output logic [7:0] o_rows
);
  // Pull-ups hold idle rows high; a pressed key pulls its row low
  assign o_rows = ~i_press;
endmodule

// *** tb/keypad_level_interrupt_tb.sv ***
// Self-checking testbench for the keypad level interrupt block
`timescale 1ns/100ps
module keypad_level_interrupt_tb;
  import keypad_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic glb = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] press = 8'h00;
  logic [7:0] rows;
  logic [7:0] rdata;
  logic irq;
  logic wake;
  logic [7:0] v;
  int n_mismatch = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  keypad_matrix_model u_keys (.i_press(press), .o_rows(rows));
  keypad_level_interrupt u_dut (
    .I_SYS_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_FIRST_IO_PORT(rows),
    .I_KEYPAD_GLOBAL_IRQ_ENABLE(glb), .I_RD(rd), .I_WR(wr), .I_ADDR(addr),
    .I_WDATA(wdata), .O_RDATA(rdata), .O_KEYPAD_IRQ_REQUEST(irq),
    .O_WAKE(wake));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    idle(2);
    rstn = 1'b1;
    rreg(LEVEL_SELECT_ADDR, v);
    chk("select reset", 8'h00, v);
    rreg(LINE_ENABLE_ADDR, v);
    chk("enable reset", 8'h00, v);
    rreg(LINE_FLAGS_ADDR, v);
    chk("flags reset", LINE_RESET, v);
    $display("test reset done");
    press = 8'h04;
    idle(3);
    chk("masked irq", 8'h00, {7'h0, irq});
    wreg(LINE_ENABLE_ADDR, 8'h04);
    idle(2);
    chk("wake", 8'h01, {7'h0, wake});
    chk("gated irq", 8'h00, {7'h0, irq});
    glb = 1'b1;
    idle(2);
    chk("irq", 8'h01, {7'h0, irq});
    $display("test mask done");
    rreg(LINE_FLAGS_ADDR, v);
    chk("held flag", 8'h04, v);
    rreg(LINE_FLAGS_ADDR, v);
    chk("flag after read", 8'h04, v);
    press = 8'h00;
    rreg(LINE_FLAGS_ADDR, v);
    chk("last flag", 8'h04, v);
    idle(1);
    rreg(LINE_FLAGS_ADDR, v);
    chk("cleared flags", 8'h00, v);
    chk("irq off", 8'h00, {7'h0, irq});
    $display("test clear done");
    wreg(LEVEL_SELECT_ADDR, 8'hf0);
    idle(2);
    rreg(LINE_FLAGS_ADDR, v);
    chk("high flags", 8'hf0, v);
    chk("other lines", 8'h00, {7'h0, irq});
    rreg(LEVEL_SELECT_ADDR, v);
    chk("select", 8'hf0, v);
    rreg(8'h9f, v);
    chk("unmapped", 8'h00, v);
    $display("test level done");
    ce = 1'b0;
    wreg(LINE_ENABLE_ADDR, 8'hff);
    ce = 1'b1;
    rreg(LINE_ENABLE_ADDR, v);
    chk("frozen enable", 8'h04, v);
    $display("test freeze done");
    rstn = 1'b0;
    idle(2);
    rstn = 1'b1;
    rreg(LINE_FLAGS_ADDR, v);
    chk("flags after reset", LINE_RESET, v);
    rreg(LEVEL_SELECT_ADDR, v);
    chk("select after reset", 8'h00, v);
    chk("wake after reset", 8'h00, {7'h0, wake});
    $display("test rereset done");
    summarize();
  end
  // Watchdog: tests need under 100 cycles
  initial begin
    #5000;
    n_mismatch++;
    summarize();
  end
endmodule
